// ==== inc/wheel_tick_pkg.sv ====
// Constants, register map and carrier types for the wheel tick input block
`default_nettype none
package wheel_tick_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int MIN_PULSE_NS = 10000;
  localparam int MIN_PULSE_CYCLES_INT = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] MIN_PULSE_CYCLES = 8'(MIN_PULSE_CYCLES_INT);
  localparam int SPEED_LEARN_KMH = 30;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] FWD_COUNT_OFFSET = 8'h08;
  localparam logic [7:0] REV_COUNT_OFFSET = 8'h0C;
  localparam logic [7:0] TOTAL_COUNT_OFFSET = 8'h10;
  localparam logic [7:0] TIME_MARK_OFFSET = 8'h14;
  localparam logic [7:0] CLEAR_OFFSET = 8'h18;
  // Control field positions
  localparam int CTRL_BOTH_EDGES_BIT = 0;
  localparam int CTRL_TIME_MARK_BIT = 1;
  localparam int CTRL_MANUAL_EN_BIT = 2;
  localparam int CTRL_MANUAL_VALUE_BIT = 3;
  localparam int CTRL_SPEED_REACHED_BIT = 4;
  localparam int CTRL_DIR_FROM_MSG_BIT = 5;
  localparam int CTRL_MSG_REVERSE_BIT = 6;
  // Status field positions
  localparam int STAT_LEARNED_BIT = 0;
  localparam int STAT_LEARNED_INVERT_BIT = 1;
  localparam int STAT_FORWARD_BIT = 2;
  localparam int STAT_TIME_MARK_SEEN_BIT = 3;
  localparam int STAT_SHORT_PULSE_BIT = 4;
  localparam int CLEAR_COUNTS_BIT = 0;
  // Reset values and responses
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] COUNT_ONE = 32'h0000_0001;

  typedef struct packed {
    logic msg_reverse;
    logic dir_from_msg;
    logic speed_reached;
    logic manual_value;
    logic manual_en;
    logic time_mark_mode;
    logic both_edges;
  } ctrl_type;

  localparam ctrl_type CTRL_RESET = '0;

  typedef struct packed {
    logic short_pulse;
    logic time_mark_seen;
    logic forward;
    logic learned_invert;
    logic learned;
  } status_type;
endpackage
`default_nettype wire

// ==== hw/pin_level_sync.sv ====
// Three-stage synchroniser that accepts a new level once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module pin_level_sync (
  // Clocking
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  // Asynchronous pin and clean level
  input wire logic i_pin,
  output logic o_level
);
  logic stage1;
  logic stage2;
  logic stage3;

  // Shift chain; stage1 feeds only stage2 to keep metastability contained
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else if (i_clk_en) begin
      stage1 <= i_pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Level moves only when the later stages agree
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_level <= 1'b0;
    end else if (i_clk_en && (stage2 == stage3)) begin
      o_level <= stage3;
    end
  end
endmodule // pin_level_sync
`default_nettype wire

// ==== hw/wheel_tick_direction_input.sv ====
// Speed pulse and direction input unit with an AXI4-Lite register slave
// How it works
// - Default mode counts one pulse on every rising edge of the speed pulse.
// - Optional mode counts both edges; sensor then needs near 1:1 mark space.
// - Time mark mode turns the pulse pin into a timestamping input.
// - Direction polarity is learned automatically once speed first reaches 30 km/h.
// - A manual polarity setting overrides the learned polarity.
// - With message direction selected, the direction pin is ignored.
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module wheel_tick_direction_input (
  // Clock, reset, enable
  input wire logic I_CORE_CLK,
  input wire logic I_RESET,
  input wire logic I_CLK_EN,
  // Vehicle pins
  input wire logic I_SPEED_PULSE_INPUT,
  input wire logic I_DIRECTION_INPUT,
  // AXI4-Lite write channels
  input wire logic [7:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  // AXI4-Lite read channels
  input wire logic [7:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY
);
  wheel_tick_pkg::ctrl_type ctrl;
  wheel_tick_pkg::status_type status;
  logic pulse_level, pulse_prev, dir_level, rise, fall, count_edge, mark_edge;
  logic forward, invert, learned, learned_invert, time_mark_seen, short_pulse;
  logic aw_full, w_full, do_write, clear_counts, status_w1c, read_hit;
  logic [3:0] w_strb;
  logic [7:0] high_cycles, aw_addr;
  logic [31:0] fwd_count, rev_count, total_count, time_mark, cycle_count;
  logic [31:0] w_data, read_word;

  // Counter step; clear restarts from the step so a coincident edge is kept
  function automatic logic [31:0] bump(input logic [31:0] value, input logic clear,
                                       input logic step);
    logic [31:0] base;
    base = clear ? wheel_tick_pkg::COUNT_RESET : value;
    bump = step ? base + wheel_tick_pkg::COUNT_ONE : base;
  endfunction

  // Known offsets only
  function automatic logic mapped(input logic [7:0] addr);
    mapped = (addr == wheel_tick_pkg::CTRL_OFFSET) || (addr == wheel_tick_pkg::STATUS_OFFSET)
      || (addr == wheel_tick_pkg::FWD_COUNT_OFFSET) || (addr == wheel_tick_pkg::REV_COUNT_OFFSET)
      || (addr == wheel_tick_pkg::TOTAL_COUNT_OFFSET) || (addr == wheel_tick_pkg::TIME_MARK_OFFSET)
      || (addr == wheel_tick_pkg::CLEAR_OFFSET);
  endfunction

  // Pin synchronisers
  pin_level_sync pulse_sync (
    .i_clk(I_CORE_CLK),
    .i_reset(I_RESET),
    .i_clk_en(I_CLK_EN),
    .i_pin(I_SPEED_PULSE_INPUT),
    .o_level(pulse_level)
  );
  pin_level_sync dir_sync (
    .i_clk(I_CORE_CLK),
    .i_reset(I_RESET),
    .i_clk_en(I_CLK_EN),
    .i_pin(I_DIRECTION_INPUT),
    .o_level(dir_level)
  );
  // Edge detection on the clean pulse level
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      pulse_prev <= 1'b0;
    end else if (I_CLK_EN) begin
      pulse_prev <= pulse_level;
    end
  end

  assign rise = I_CLK_EN && pulse_level && !pulse_prev;
  assign fall = I_CLK_EN && !pulse_level && pulse_prev;
  // Rising edge counts outside time mark mode, falling edge only in both-edge mode
  assign count_edge = !ctrl.time_mark_mode && (rise || (ctrl.both_edges && fall));
  assign mark_edge = ctrl.time_mark_mode && rise;
  // Polarity: manual wins over learned
  assign invert = ctrl.manual_en ? ctrl.manual_value : learned_invert;
  // Message direction bypasses the pin entirely
  assign forward = ctrl.dir_from_msg ? !ctrl.msg_reverse : (dir_level ^ invert);

  // Polarity learned once: vehicle assumed moving forward when speed threshold is first met
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      learned <= 1'b0;
      learned_invert <= 1'b0;
    end else if (I_CLK_EN && ctrl.speed_reached && !learned) begin
      learned <= 1'b1;
      learned_invert <= !dir_level;
    end
  end

  // Free-running timestamp base
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      cycle_count <= wheel_tick_pkg::COUNT_RESET;
    end else if (I_CLK_EN) begin
      cycle_count <= cycle_count + wheel_tick_pkg::COUNT_ONE;
    end
  end

  // Pulse counters, direction sampled at the counted edge
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      fwd_count <= wheel_tick_pkg::COUNT_RESET;
      rev_count <= wheel_tick_pkg::COUNT_RESET;
      total_count <= wheel_tick_pkg::COUNT_RESET;
    end else if (I_CLK_EN) begin
      total_count <= bump(total_count, clear_counts, count_edge);
      fwd_count <= bump(fwd_count, clear_counts, count_edge && forward);
      rev_count <= bump(rev_count, clear_counts, count_edge && !forward);
    end
  end

  // Time mark capture; the seen flag's set beats a software clear
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      time_mark <= wheel_tick_pkg::COUNT_RESET;
      time_mark_seen <= 1'b0;
    end else if (I_CLK_EN) begin
      if (mark_edge) begin
        time_mark <= cycle_count;
        time_mark_seen <= 1'b1;
      end else if (status_w1c && w_data[wheel_tick_pkg::STAT_TIME_MARK_SEEN_BIT]) begin
        time_mark_seen <= 1'b0;
      end
    end
  end

  // Width monitor: high phases under the minimum width are flagged for software
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      high_cycles <= 8'h00;
      short_pulse <= 1'b0;
    end else if (I_CLK_EN) begin
      if (!pulse_level) begin
        high_cycles <= 8'h00;
      end else if (high_cycles != wheel_tick_pkg::MIN_PULSE_CYCLES) begin
        high_cycles <= high_cycles + 8'h01;
      end
      if (fall && (high_cycles < wheel_tick_pkg::MIN_PULSE_CYCLES)) begin
        short_pulse <= 1'b1;
      end else if (status_w1c && w_data[wheel_tick_pkg::STAT_SHORT_PULSE_BIT]) begin
        short_pulse <= 1'b0;
      end
    end
  end

  assign status = '{short_pulse: short_pulse, time_mark_seen: time_mark_seen,
                    forward: forward, learned_invert: learned_invert, learned: learned};

  // Write side: address and data latched in either order
  assign O_AWREADY = I_CLK_EN && !aw_full && !O_BVALID;
  assign O_WREADY = I_CLK_EN && !w_full && !O_BVALID;
  assign do_write = I_CLK_EN && aw_full && w_full && !O_BVALID;
  assign clear_counts = do_write && (aw_addr == wheel_tick_pkg::CLEAR_OFFSET)
    && w_strb[0] && w_data[wheel_tick_pkg::CLEAR_COUNTS_BIT];
  assign status_w1c = do_write && (aw_addr == wheel_tick_pkg::STATUS_OFFSET) && w_strb[0];
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= wheel_tick_pkg::COUNT_RESET;
      w_strb <= 4'h0;
      O_BVALID <= 1'b0;
      O_BRESP <= wheel_tick_pkg::RESP_OKAY;
    end else if (I_CLK_EN) begin
      if (O_AWREADY && I_AWVALID) begin
        aw_full <= 1'b1;
        aw_addr <= I_AWADDR;
      end
      if (O_WREADY && I_WVALID) begin
        w_full <= 1'b1;
        w_data <= I_WDATA;
        w_strb <= I_WSTRB;
      end
      if (do_write) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        O_BVALID <= 1'b1;
        O_BRESP <= mapped(aw_addr) ? wheel_tick_pkg::RESP_OKAY : wheel_tick_pkg::RESP_SLVERR;
      end else if (O_BVALID && I_BREADY) begin
        O_BVALID <= 1'b0;
      end
    end
  end

  // Control register, low byte lane only
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      ctrl <= wheel_tick_pkg::CTRL_RESET;
    end else if (do_write && (aw_addr == wheel_tick_pkg::CTRL_OFFSET) && w_strb[0]) begin
      ctrl.both_edges <= w_data[wheel_tick_pkg::CTRL_BOTH_EDGES_BIT];
      ctrl.time_mark_mode <= w_data[wheel_tick_pkg::CTRL_TIME_MARK_BIT];
      ctrl.manual_en <= w_data[wheel_tick_pkg::CTRL_MANUAL_EN_BIT];
      ctrl.manual_value <= w_data[wheel_tick_pkg::CTRL_MANUAL_VALUE_BIT];
      ctrl.speed_reached <= w_data[wheel_tick_pkg::CTRL_SPEED_REACHED_BIT];
      ctrl.dir_from_msg <= w_data[wheel_tick_pkg::CTRL_DIR_FROM_MSG_BIT];
      ctrl.msg_reverse <= w_data[wheel_tick_pkg::CTRL_MSG_REVERSE_BIT];
    end
  end

  // Read decode; unmapped reads answer zero with SLVERR
  always_comb begin
    read_word = wheel_tick_pkg::COUNT_RESET;
    read_hit = 1'b1;
    case (I_ARADDR)
      wheel_tick_pkg::CTRL_OFFSET: read_word = {25'h000_0000, ctrl};
      wheel_tick_pkg::STATUS_OFFSET: read_word = {27'h000_0000, status};
      wheel_tick_pkg::FWD_COUNT_OFFSET: read_word = fwd_count;
      wheel_tick_pkg::REV_COUNT_OFFSET: read_word = rev_count;
      wheel_tick_pkg::TOTAL_COUNT_OFFSET: read_word = total_count;
      wheel_tick_pkg::TIME_MARK_OFFSET: read_word = time_mark;
      wheel_tick_pkg::CLEAR_OFFSET: read_word = wheel_tick_pkg::COUNT_RESET;
      default: read_hit = 1'b0;
    endcase
  end

  // One read in flight; data registered
  assign O_ARREADY = I_CLK_EN && !O_RVALID;
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      O_RVALID <= 1'b0;
      O_RDATA <= wheel_tick_pkg::COUNT_RESET;
      O_RRESP <= wheel_tick_pkg::RESP_OKAY;
    end else if (I_CLK_EN) begin
      if (O_ARREADY && I_ARVALID) begin
        O_RVALID <= 1'b1;
        O_RDATA <= read_word;
        O_RRESP <= read_hit ? wheel_tick_pkg::RESP_OKAY : wheel_tick_pkg::RESP_SLVERR;
      end else if (O_RVALID && I_RREADY) begin
        O_RVALID <= 1'b0;
      end
    end
  end

  // Checks
  sequence counted_rise;
    rise && !ctrl.time_mark_mode && !clear_counts;
  endsequence
  sequence counted_fall;
    fall && ctrl.both_edges && !ctrl.time_mark_mode && !clear_counts;
  endsequence
  rise_counts_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    counted_rise |=> total_count == $past(total_count) + wheel_tick_pkg::COUNT_ONE)
    else $error("rising edge not counted");
  fall_ignored_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    fall && !ctrl.both_edges && !clear_counts |=> $stable(total_count))
    else $error("falling edge counted in single edge mode");
  both_edges_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    counted_fall |=> total_count == $past(total_count) + wheel_tick_pkg::COUNT_ONE)
    else $error("falling edge missed in both edge mode");
  // A clear in the same cycle may still zero the total; only counting is ruled out
  mark_stamp_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    mark_edge |=> time_mark == $past(cycle_count) && time_mark_seen
      && total_count == ($past(clear_counts) ? wheel_tick_pkg::COUNT_RESET : $past(total_count)))
    else $error("time mark not captured");
  learn_once_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    $rose(learned) |-> $past(ctrl.speed_reached) && learned_invert == !$past(dir_level))
    else $error("polarity learned without speed threshold");
  manual_pol_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    ctrl.manual_en && !ctrl.dir_from_msg |-> forward == (dir_level ^ ctrl.manual_value))
    else $error("manual polarity not applied");
  msg_dir_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    ctrl.dir_from_msg |-> forward == !ctrl.msg_reverse)
    else $error("direction pin used in message mode");
  dir_split_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    (counted_rise or counted_fall) ##0 !forward |=> rev_count == $past(rev_count)
      + wheel_tick_pkg::COUNT_ONE ##0 $stable(fwd_count))
    else $error("reverse pulse not split correctly");
  short_flag_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    fall && high_cycles < wheel_tick_pkg::MIN_PULSE_CYCLES |=> short_pulse)
    else $error("short pulse not flagged");
endmodule // wheel_tick_direction_input
`default_nettype wire

// ==== bench/wheel_sensor_model.sv ====
// Behavioural wheel speed sensor with a direction level output
`timescale 1ns/100ps
`default_nettype none
module wheel_sensor_model (
  // Clock and burst request
  input wire logic i_clk,
  input wire logic i_go,
  // Burst shape
  input wire logic [7:0] i_count,
  input wire logic [15:0] i_high,
  input wire logic [15:0] i_low,
  input wire logic i_dir_level,
  // Sensor pins and status
  output logic o_pulse,
  output logic o_dir,
  output logic o_busy
);
  // One burst per request; the pulse line rests low between bursts
  initial begin
    o_pulse = 1'b0;
    o_dir = 1'b1;
    o_busy = 1'b0;
    forever begin
      @(posedge i_clk);
      if (i_go) begin
        o_busy <= 1'b1;
        o_dir <= i_dir_level;
        // Fixed period per burst, so rate tracks one steady speed
        repeat (i_count) begin
          repeat (i_low) @(posedge i_clk);
          o_pulse <= 1'b1;
          repeat (i_high) @(posedge i_clk);
          o_pulse <= 1'b0;
        end
        repeat (i_low) @(posedge i_clk);
        o_busy <= 1'b0;
      end
    end
  end
endmodule // wheel_sensor_model
`default_nettype wire

// ==== bench/wheel_tick_direction_input_tb.sv ====
// Self-checking bench for the wheel tick input block
`timescale 1ns/100ps
`default_nettype none
module wheel_tick_direction_input_tb;
  logic clk, reset, go, pulse, dir, busy, lvl, clk_en;
  logic [7:0] count, awaddr, araddr;
  logic [15:0] high, low;
  logic [31:0] wdata, rdata, got;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, resp;
  int n_mismatch, tests_run;

  // Free running clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  wheel_sensor_model i_wheel_sensor_model (.i_clk(clk), .i_go(go), .i_count(count),
    .i_high(high), .i_low(low), .i_dir_level(lvl), .o_pulse(pulse), .o_dir(dir),
    .o_busy(busy));

  // Strobes tied: only byte lane zero carries fields
  wheel_tick_direction_input i_wheel_tick_direction_input (.I_CORE_CLK(clk),
    .I_RESET(reset), .I_CLK_EN(clk_en), .I_SPEED_PULSE_INPUT(pulse),
    .I_DIRECTION_INPUT(dir), .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
    .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wvalid), .O_WREADY(wready),
    .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr),
    .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp),
    .O_RVALID(rvalid), .I_RREADY(rready));

  task automatic check_word(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH at %0t: word %h expected %h", $time, g, e);
    end
  endtask

  task automatic check_resp(input logic [1:0] g, input logic [1:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH at %0t: response %h expected %h", $time, g, e);
    end
  endtask

  // Handshakes judged at the falling edge, where inputs and readies are settled
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok, ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(negedge clk);
      aw_ok = aw_ok || awready;
      w_ok = w_ok || wready;
      @(posedge clk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    do begin
      @(negedge clk);
      ok = bvalid;
      r = bresp;
      @(posedge clk);
    end while (!ok);
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ok;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      ok = arready;
      @(posedge clk);
    end while (!ok);
    arvalid <= 1'b0;
    do begin
      @(negedge clk);
      ok = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
    end while (!ok);
    rready <= 1'b0;
  endtask

  task automatic expect_reg(input logic [7:0] a, input logic [31:0] e);
    axi_read(a, got, resp);
    check_resp(resp, wheel_tick_pkg::RESP_OKAY);
    check_word(got, e);
  endtask

  task automatic set_reg(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d, resp);
    check_resp(resp, wheel_tick_pkg::RESP_OKAY);
  endtask

  task automatic check_counts(input logic [31:0] f, input logic [31:0] r, input logic [31:0] t);
    expect_reg(wheel_tick_pkg::FWD_COUNT_OFFSET, f);
    expect_reg(wheel_tick_pkg::REV_COUNT_OFFSET, r);
    expect_reg(wheel_tick_pkg::TOTAL_COUNT_OFFSET, t);
  endtask

  // Fire one sensor burst and wait for its trailing low phase to end
  task automatic run_pulses(input logic [7:0] n, input logic [15:0] h, input logic [15:0] l,
                            input logic d);
    @(posedge clk);
    count <= n;
    high <= h;
    low <= l;
    lvl <= d;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    while (busy) @(posedge clk);
  endtask

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Whole sequence needs roughly 7600 cycles
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    complete_run;
  end

  initial begin
    {reset, go, lvl, awvalid, wvalid, bready, arvalid, rready} = 8'h80;
    clk_en = 1'b1;
    {count, awaddr, araddr, high, low, wdata} = '0;
    n_mismatch = 0;
    tests_run = 0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    expect_reg(wheel_tick_pkg::CTRL_OFFSET, 32'h0000_0000);
    expect_reg(wheel_tick_pkg::STATUS_OFFSET, 32'h0000_0004);
    check_counts(32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    // Rising edges only with a forward level, then both edges with a reverse level
    run_pulses(8'h03, 16'h00DC, 16'h00DC, 1'b1);
    check_counts(32'h0000_0003, 32'h0000_0000, 32'h0000_0003);
    set_reg(wheel_tick_pkg::CTRL_OFFSET, 32'h0000_0001);
    set_reg(wheel_tick_pkg::CLEAR_OFFSET, 32'h0000_0001);
    run_pulses(8'h02, 16'h00DC, 16'h00DC, 1'b0);
    check_counts(32'h0000_0000, 32'h0000_0004, 32'h0000_0004);
    // Narrow pulse is flagged, then cleared by writing one
    set_reg(wheel_tick_pkg::CTRL_OFFSET, 32'h0000_0000);
    run_pulses(8'h01, 16'h0064, 16'h00DC, 1'b0);
    expect_reg(wheel_tick_pkg::STATUS_OFFSET, 32'h0000_0010);
    set_reg(wheel_tick_pkg::STATUS_OFFSET, 32'h0000_0010);
    expect_reg(wheel_tick_pkg::STATUS_OFFSET, 32'h0000_0000);
    // Manual inversion turns a high level into reverse
    set_reg(wheel_tick_pkg::CTRL_OFFSET, 32'h0000_000C);
    set_reg(wheel_tick_pkg::CLEAR_OFFSET, 32'h0000_0001);
    run_pulses(8'h01, 16'h00DC, 16'h00DC, 1'b1);
    check_counts(32'h0000_0000, 32'h0000_0001, 32'h0000_0001);
    // Learning at speed with a low level means the pin is inverted
    run_pulses(8'h00, 16'h00DC, 16'h0010, 1'b0);
    set_reg(wheel_tick_pkg::CTRL_OFFSET, 32'h0000_0010);
    expect_reg(wheel_tick_pkg::STATUS_OFFSET, 32'h0000_0007);
    set_reg(wheel_tick_pkg::CLEAR_OFFSET, 32'h0000_0001);
    run_pulses(8'h01, 16'h00DC, 16'h00DC, 1'b0);
    check_counts(32'h0000_0001, 32'h0000_0000, 32'h0000_0001);
    // Message direction wins over a pin that says forward
    set_reg(wheel_tick_pkg::CTRL_OFFSET, 32'h0000_0070);
    set_reg(wheel_tick_pkg::CLEAR_OFFSET, 32'h0000_0001);
    run_pulses(8'h02, 16'h00DC, 16'h00DC, 1'b0);
    check_counts(32'h0000_0000, 32'h0000_0002, 32'h0000_0002);
    expect_reg(wheel_tick_pkg::STATUS_OFFSET, 32'h0000_0003);
    // Enable low freezes the synchronisers, so a whole burst leaves the counts alone
    clk_en <= 1'b0;
    run_pulses(8'h02, 16'h00DC, 16'h00DC, 1'b0);
    clk_en <= 1'b1;
    check_counts(32'h0000_0000, 32'h0000_0002, 32'h0000_0002);
    // Time mark mode stamps instead of counting
    set_reg(wheel_tick_pkg::CTRL_OFFSET, 32'h0000_0012);
    set_reg(wheel_tick_pkg::CLEAR_OFFSET, 32'h0000_0001);
    run_pulses(8'h01, 16'h00DC, 16'h00DC, 1'b0);
    check_counts(32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    expect_reg(wheel_tick_pkg::STATUS_OFFSET, 32'h0000_000F);
    axi_read(wheel_tick_pkg::TIME_MARK_OFFSET, got, resp);
    check_word(32'(got != 32'h0000_0000), 32'h0000_0001);
    // Unmapped places answer with a slave error
    axi_read(8'h1C, got, resp);
    check_resp(resp, wheel_tick_pkg::RESP_SLVERR);
    check_word(got, 32'h0000_0000);
    axi_write(8'h20, 32'h0000_0001, resp);
    check_resp(resp, wheel_tick_pkg::RESP_SLVERR);
    complete_run;
  end
endmodule // wheel_tick_direction_input_tb
`default_nettype wire
